/* File: hw/rx_link_pkg.sv */
/*
 * Shared constants and types of the receive lock-source and link fault block.
 * Assumes a single clock domain and a synchronous active-low reset.
 */
`default_nettype none

package rx_link_pkg;

	localparam int unsigned AXI_ADDR_W = 4;
	localparam int unsigned AXI_DATA_W = 32;

	localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET = 4'h0;
	localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 4'h4;
	localparam logic [AXI_ADDR_W-1:0] INT_STATUS_OFFSET = 4'h8;
	localparam logic [AXI_ADDR_W-1:0] INT_MASK_OFFSET = 4'hC;

	localparam int unsigned CTRL_TRIP_LSB = 0;
	localparam int unsigned CTRL_CHAN_EN_BIT = 2;
	localparam logic [1:0] TRIP_RESET = 2'h0;
	localparam logic CHAN_EN_RESET = 1'b1;
	localparam logic [5:0] INT_MASK_RESET = 6'h00;

	localparam int unsigned STATUS_FAULT_LSB = 0;
	localparam int unsigned STATUS_LOCK_BIT = 8;
	localparam int unsigned STATUS_LINK_FAULT_N_BIT = 9;
	localparam int unsigned STATUS_RX_RATE_LSB = 12;
	localparam int unsigned STATUS_TX_RATE_LSB = 14;

	localparam int unsigned FAULT_COUNT = 6;
	localparam int unsigned FAULT_RATE = 0;
	localparam int unsigned FAULT_AMPLITUDE = 1;
	localparam int unsigned FAULT_DENSITY = 2;
	localparam int unsigned FAULT_CHAN_OFF = 3;
	localparam int unsigned FAULT_LOCAL_CLK = 4;
	localparam int unsigned FAULT_NO_TRAINING = 5;

	localparam int unsigned DENSITY_LIMIT_BITS = 60;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [10:0] LOW_MIN_MBD = 11'h0C3;
	localparam logic [10:0] LOW_MAX_MBD = 11'h190;
	localparam logic [10:0] MID_MIN_MBD = 11'h190;
	localparam logic [10:0] MID_MAX_MBD = 11'h320;
	localparam logic [10:0] HIGH_MIN_MBD = 11'h320;
	localparam logic [10:0] HIGH_MAX_MBD = 11'h5DC;

	typedef enum logic [1:0]
	{
		RATE_LOW = 2'h0,
		RATE_MID = 2'h1,
		RATE_HIGH = 2'h2
	} rate_level_t;

	typedef struct packed
	{
		logic [10:0] min_mbd;
		logic [10:0] max_mbd;
	} rate_range_t;

	typedef struct packed
	{
		logic level_ok;
		logic rate_in_range;
		logic training_clock_present;
	} analog_status_t;

endpackage

`default_nettype wire

/* File: hw/transition_density_monitor.sv */
/*
 * Run-length check on the selected serial bit stream, one bit per clock.
 * Assumes the bits arrive synchronous to aclk.
 */
`default_nettype none

module transition_density_monitor
#(
	parameter int unsigned LIMIT = rx_link_pkg::DENSITY_LIMIT_BITS
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic serial_bit,
	output logic density_ok
);
	import rx_link_pkg::*;

	typedef struct packed
	{
		logic [7:0] run_len;
		logic last_bit;
		logic ok;
	} mon_state_t;

	mon_state_t state_reg;
	mon_state_t state_next;

	if (LIMIT < 2 || LIMIT > 255)
	begin : g_limit_check
		$error("LIMIT out of range.");
	end

	// A run of LIMIT equal bits holds no transition and fails the check.
	always_comb
	begin
		state_next = state_reg;
		state_next.last_bit = serial_bit;
		if (serial_bit != state_reg.last_bit)
			state_next.run_len = 8'h01;
		else if (state_reg.run_len < 8'(LIMIT))
			state_next.run_len = state_reg.run_len + 8'h01;
		state_next.ok = (state_next.run_len < 8'(LIMIT));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg.run_len <= 8'h01;
			state_reg.last_bit <= 1'b0;
			state_reg.ok <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	assign density_ok = state_reg.ok;

endmodule

`default_nettype wire

/* File: hw/rx_lock_source_link_fault.sv */
/*
 * Receive lock-source selection, input selection, rate decode and link fault
 * indicator, with an AXI4-Lite register slave and a level interrupt.
 * Assumes all inputs are synchronous to aclk and the serial inputs are sampled
 * one bit per clock.
 */
// Chosen here: the AXI4-Lite register port and the address map.
// Operation
// - Detector enable on uses all three detectors.
// - Any detector fault holds PLL on training clock.
// - Density fails without transition in 60 bits.
// - Two-bit field sets level detector trip.
// - Detector enable off uses range controller only.
// - Local clock low forces training clock lock.
// - Local clock low drives link fault low.
// - Local clock high recovers selected serial stream.
// - Rate selects decode to three baud ranges.
// - Input select high primary, low secondary.
// - Link fault is active-low OR of six.
// - Out-of-range data rate asserts link fault.
// - Other faults: amplitude, density, disabled, local clock, training clock.
`default_nettype none

module rx_lock_source_link_fault
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [rx_link_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [rx_link_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [rx_link_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [rx_link_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic detector_enable,
	input wire logic use_local_clock,
	input wire logic rx_input_select,
	input wire logic [1:0] rx_rate_range_sel,
	input wire logic [1:0] tx_rate_range_sel,
	input wire logic primary_serial_in,
	input wire logic secondary_serial_in,
	input wire rx_link_pkg::analog_status_t analog_status,
	output logic [1:0] level_trip_select,
	output logic receive_pll_tracks_data,
	output logic cdr_serial_bit,
	output rx_link_pkg::rate_range_t rx_rate_range,
	output rx_link_pkg::rate_range_t tx_rate_range,
	output logic link_fault_n,
	output logic irq
);
	import rx_link_pkg::*;

	typedef struct packed
	{
		logic [1:0] trip;
		logic chan_en;
		logic [FAULT_COUNT-1:0] int_status;
		logic [FAULT_COUNT-1:0] int_mask;
		logic [FAULT_COUNT-1:0] fault_prev;
		rate_level_t rx_rate;
		rate_level_t tx_rate;
		logic rate_captured;
		logic lock_data;
		logic cdr_bit;
		logic link_fault_n;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [AXI_DATA_W-1:0] rdata;
		rate_range_t rx_range;
		rate_range_t tx_range;
	} block_state_t;

	block_state_t state_reg;
	block_state_t state_next;

	logic selected_bit;
	logic density_ok;
	logic [FAULT_COUNT-1:0] faults;
	logic lock_to_data;
	logic wr_fire;
	logic rd_fire;
	logic [FAULT_COUNT-1:0] rd_clear;
	logic [FAULT_COUNT-1:0] int_status_next;

	// Elaboration checks refuse constants that the register map cannot serve.
	if (AXI_DATA_W != 32)
	begin : g_data_width_check
		$error("The register slave serves 32-bit words only.");
	end

	if (AXI_ADDR_W < 4)
	begin : g_addr_width_check
		$error("Register offsets do not fit the address width.");
	end

	if (FAULT_COUNT < 6 || FAULT_COUNT > 8)
	begin : g_fault_count_check
		$error("The fault vector must hold six to eight bits.");
	end

	if (STATUS_FAULT_LSB + FAULT_COUNT > STATUS_LOCK_BIT)
	begin : g_status_field_check
		$error("Fault field overlaps the lock bit.");
	end

	if (STATUS_LINK_FAULT_N_BIT >= STATUS_RX_RATE_LSB || STATUS_RX_RATE_LSB + 2 > STATUS_TX_RATE_LSB)
	begin : g_status_order_check
		$error("Status fields overlap.");
	end

	if (STATUS_TX_RATE_LSB + 2 > AXI_DATA_W)
	begin : g_status_top_check
		$error("Rate codes exceed the data word.");
	end

	if (CTRL_TRIP_LSB + 2 > CTRL_CHAN_EN_BIT || CTRL_CHAN_EN_BIT > 7)
	begin : g_ctrl_field_check
		$error("Control fields overlap or leave byte lane zero.");
	end

	if (LOW_MAX_MBD != MID_MIN_MBD || MID_MAX_MBD != HIGH_MIN_MBD || LOW_MIN_MBD >= LOW_MAX_MBD
		|| MID_MIN_MBD >= MID_MAX_MBD || HIGH_MIN_MBD >= HIGH_MAX_MBD)
	begin : g_rate_range_check
		$error("Rate ranges do not join in rising order.");
	end

	function automatic rate_level_t decode_level(input logic [1:0] sel);
		rate_level_t lvl;
		unique case (sel)
			2'h0: lvl = RATE_LOW;
			2'h2: lvl = RATE_HIGH;
			default: lvl = RATE_MID;
		endcase
		return lvl;
	endfunction

	function automatic rate_range_t range_of(input rate_level_t lvl);
		rate_range_t r;
		unique case (lvl)
			RATE_LOW:
			begin
				r.min_mbd = LOW_MIN_MBD;
				r.max_mbd = LOW_MAX_MBD;
			end
			RATE_HIGH:
			begin
				r.min_mbd = HIGH_MIN_MBD;
				r.max_mbd = HIGH_MAX_MBD;
			end
			default:
			begin
				r.min_mbd = MID_MIN_MBD;
				r.max_mbd = MID_MAX_MBD;
			end
		endcase
		return r;
	endfunction

	// Primary input when the selector is high, secondary when low.
	assign selected_bit = rx_input_select ? primary_serial_in : secondary_serial_in;

	transition_density_monitor #(
		.LIMIT(DENSITY_LIMIT_BITS)
	) u_density (
		.aclk(aclk),
		.aresetn(aresetn),
		.serial_bit(selected_bit),
		.density_ok(density_ok)
	);

	// Six fault conditions feeding the indicator.
	always_comb
	begin
		faults = '0;
		faults[FAULT_RATE] = !analog_status.rate_in_range;
		faults[FAULT_AMPLITUDE] = !analog_status.level_ok;
		faults[FAULT_DENSITY] = !density_ok;
		faults[FAULT_CHAN_OFF] = !state_reg.chan_en;
		faults[FAULT_LOCAL_CLK] = !use_local_clock;
		faults[FAULT_NO_TRAINING] = !analog_status.training_clock_present;
	end

	// With the local clock input high and the detectors enabled all three must be valid; with them disabled only the range controller counts.
	always_comb
	begin
		if (!use_local_clock)
			lock_to_data = 1'b0;
		else if (detector_enable)
			lock_to_data = analog_status.rate_in_range && analog_status.level_ok && density_ok;
		else
			lock_to_data = analog_status.rate_in_range;
	end

	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
	assign s_axi_wready = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
	assign s_axi_arready = !state_reg.rvalid;
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
	assign rd_fire = s_axi_arvalid && !state_reg.rvalid;
	assign rd_clear = (rd_fire && s_axi_araddr == INT_STATUS_OFFSET) ? state_reg.int_status : '0;

	// Each sticky bit latches the rising edge of its fault; a clearing read in the same cycle loses.
	for (genvar i = 0; i < FAULT_COUNT; i++)
	begin : g_int_bit
		assign int_status_next[i] = (state_reg.int_status[i] && !rd_clear[i])
			|| (faults[i] && !state_reg.fault_prev[i]);
	end

	always_comb
	begin
		state_next = state_reg;
		state_next.fault_prev = faults;
		state_next.lock_data = lock_to_data;
		// Recovery runs on the selected stream only while the local clock input is high.
		state_next.cdr_bit = use_local_clock ? selected_bit : 1'b0;
		state_next.link_fault_n = ~(|faults);
		// Rate selects are static and are caught once after reset.
		if (!state_reg.rate_captured)
		begin
			state_next.rate_captured = 1'b1;
			state_next.rx_rate = decode_level(rx_rate_range_sel);
			state_next.tx_rate = decode_level(tx_rate_range_sel);
		end
		state_next.rx_range = range_of(state_reg.rx_rate);
		state_next.tx_range = range_of(state_reg.tx_rate);
		state_next.int_status = int_status_next;
		if (state_reg.bvalid && s_axi_bready)
			state_next.bvalid = 1'b0;
		if (wr_fire)
		begin
			state_next.bvalid = 1'b1;
			state_next.bresp = RESP_OKAY;
			unique case (s_axi_awaddr)
				CTRL_OFFSET:
				begin
					if (s_axi_wstrb[0])
					begin
						state_next.trip = s_axi_wdata[CTRL_TRIP_LSB +: 2];
						state_next.chan_en = s_axi_wdata[CTRL_CHAN_EN_BIT];
					end
				end
				INT_MASK_OFFSET:
				begin
					if (s_axi_wstrb[0])
						state_next.int_mask = s_axi_wdata[FAULT_COUNT-1:0];
				end
				STATUS_OFFSET, INT_STATUS_OFFSET:
				begin
					state_next.bresp = RESP_OKAY;
				end
				default:
				begin
					state_next.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (state_reg.rvalid && s_axi_rready)
			state_next.rvalid = 1'b0;
		if (rd_fire)
		begin
			state_next.rvalid = 1'b1;
			state_next.rresp = RESP_OKAY;
			state_next.rdata = '0;
			unique case (s_axi_araddr)
				CTRL_OFFSET:
				begin
					state_next.rdata[CTRL_TRIP_LSB +: 2] = state_reg.trip;
					state_next.rdata[CTRL_CHAN_EN_BIT] = state_reg.chan_en;
				end
				STATUS_OFFSET:
				begin
					state_next.rdata[STATUS_FAULT_LSB +: FAULT_COUNT] = faults;
					state_next.rdata[STATUS_LOCK_BIT] = state_reg.lock_data;
					state_next.rdata[STATUS_LINK_FAULT_N_BIT] = state_reg.link_fault_n;
					state_next.rdata[STATUS_RX_RATE_LSB +: 2] = state_reg.rx_rate;
					state_next.rdata[STATUS_TX_RATE_LSB +: 2] = state_reg.tx_rate;
				end
				INT_STATUS_OFFSET:
				begin
					state_next.rdata[FAULT_COUNT-1:0] = state_reg.int_status;
				end
				INT_MASK_OFFSET:
				begin
					state_next.rdata[FAULT_COUNT-1:0] = state_reg.int_mask;
				end
				default:
				begin
					state_next.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg.trip <= TRIP_RESET;
			state_reg.chan_en <= CHAN_EN_RESET;
			state_reg.int_status <= '0;
			state_reg.int_mask <= INT_MASK_RESET;
			state_reg.fault_prev <= '0;
			state_reg.rx_rate <= RATE_MID;
			state_reg.tx_rate <= RATE_MID;
			state_reg.rate_captured <= 1'b0;
			state_reg.lock_data <= 1'b0;
			state_reg.cdr_bit <= 1'b0;
			state_reg.link_fault_n <= 1'b0;
			state_reg.bvalid <= 1'b0;
			state_reg.bresp <= RESP_OKAY;
			state_reg.rvalid <= 1'b0;
			state_reg.rresp <= RESP_OKAY;
			state_reg.rdata <= '0;
			state_reg.rx_range <= '0;
			state_reg.tx_range <= '0;
		end
		else
			state_reg <= state_next;
	end

	assign level_trip_select = state_reg.trip;
	assign receive_pll_tracks_data = state_reg.lock_data;
	assign cdr_serial_bit = state_reg.cdr_bit;
	assign rx_rate_range = state_reg.rx_range;
	assign tx_rate_range = state_reg.tx_range;
	assign link_fault_n = state_reg.link_fault_n;
	assign irq = |(state_reg.int_status & state_reg.int_mask);
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rresp = state_reg.rresp;
	assign s_axi_rdata = state_reg.rdata;

endmodule

`default_nettype wire

/* File: tb/serial_tx_model.sv */
/*
 * Remote serial transmitter: two streams of line bits, one bit per clock.
 * Assumes the bench raises stall to freeze both lines for a density test.
 */
`default_nettype none
module serial_tx_model
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic stall,
	output logic primary_serial_in,
	output logic secondary_serial_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] pat_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pat_reg <= 4'h1;
		else if (!stall)
			pat_reg <= {pat_reg[2:0], pat_reg[3] ^ pat_reg[2]};
	end
	assign primary_serial_in = pat_reg[0];
	assign secondary_serial_in = pat_reg[3];
endmodule
`default_nettype wire

/* File: tb/rx_link_sva.sv */
/*
 * Link-side assertions of the lock-source block.
 * Assumes it is bound to the block and sees only its ports.
 */
`default_nettype none
module rx_link_sva
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic detector_enable,
	input wire logic use_local_clock,
	input wire logic rx_input_select,
	input wire logic primary_serial_in,
	input wire logic secondary_serial_in,
	input wire rx_link_pkg::analog_status_t analog_status,
	input wire logic receive_pll_tracks_data,
	input wire logic cdr_serial_bit,
	input wire rx_link_pkg::rate_range_t rx_rate_range,
	input wire logic link_fault_n
);
	timeunit 1ns;
	timeprecision 1ns;
	import rx_link_pkg::*;
	logic cur;
	logic sel_reg;
	logic [6:0] run_reg;
	logic [2:0] age_reg;
	assign cur = rx_input_select ? primary_serial_in : secondary_serial_in;
	always_ff @(posedge aclk)
	begin
		sel_reg <= !aresetn ? 1'b0 : cur;
		run_reg <= (!aresetn || cur != sel_reg) ? 7'h00 : run_reg + {6'h00, run_reg != 7'h7F};
		age_reg <= !aresetn ? 3'h0 : age_reg + {2'h0, age_reg != 3'h7};
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_local_fault: assert property (!use_local_clock |=> !link_fault_n)
		else $error("Fault missing in local clock mode.");
	a_local_train: assert property (!use_local_clock |=> !receive_pll_tracks_data)
		else $error("Lock left training clock.");
	a_rate_fault: assert property (!analog_status.rate_in_range |=> !link_fault_n)
		else $error("Rate fault not shown.");
	a_amp_fault: assert property (!analog_status.level_ok |=> !link_fault_n)
		else $error("Amplitude fault not shown.");
	a_clock_fault: assert property (!analog_status.training_clock_present |=> !link_fault_n)
		else $error("Missing clock not shown.");
	a_det_hold: assert property (detector_enable && !analog_status.level_ok |=> !receive_pll_tracks_data)
		else $error("Lock kept on bad level.");
	a_range_only: assert property (!detector_enable && use_local_clock && analog_status.rate_in_range
		|=> receive_pll_tracks_data)
		else $error("Range alone did not lock.");
	a_serial_pass: assert property (use_local_clock |=> cdr_serial_bit == sel_reg)
		else $error("Wrong serial input recovered.");
	a_density_fault: assert property (run_reg >= 7'(DENSITY_LIMIT_BITS) |-> !link_fault_n)
		else $error("Density fault not shown.");
	a_range_static: assert property (age_reg == 3'h7 |-> $stable(rx_rate_range))
		else $error("Rate range changed after reset.");
endmodule
bind rx_lock_source_link_fault rx_link_sva i_chk (.aclk, .aresetn, .detector_enable, .use_local_clock,
	.rx_input_select, .primary_serial_in, .secondary_serial_in, .analog_status, .receive_pll_tracks_data,
	.cdr_serial_bit, .rx_rate_range, .link_fault_n);
`default_nettype wire

/* File: tb/testbench.sv */
/*
 * Self-checking bench of the lock-source block.
 * Assumes the serial transmitter model and the bound checker.
 */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import rx_link_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cap, seed = 32'h5F;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, level_trip_select, rx_rate_range_sel = 2'h0, tx_rate_range_sel = 2'h0;
	logic detector_enable = 1'b1, use_local_clock = 1'b1, rx_input_select = 1'b1;
	logic primary_serial_in, secondary_serial_in, receive_pll_tracks_data, cdr_serial_bit, link_fault_n;
	analog_status_t analog_status = 3'h7;
	rate_range_t rx_rate_range, tx_rate_range;
	int failures = 0, cmp_count = 0;
	always #25 aclk = ~aclk;
	serial_tx_model i_tx (.aclk, .aresetn, .stall, .primary_serial_in, .secondary_serial_in);
	rx_lock_source_link_fault i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .detector_enable, .use_local_clock, .rx_input_select,
		.rx_rate_range_sel, .tx_rate_range_sel, .primary_serial_in, .secondary_serial_in, .analog_status,
		.level_trip_select, .receive_pll_tracks_data, .cdr_serial_bit, .rx_rate_range, .tx_rate_range,
		.link_fault_n, .irq);
	task automatic report_and_stop();
		$display("compares=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		cmp_count++;
		if (act !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [31:0] rng(input logic [1:0] s);
		if (s == 2'h0)
			return {10'h0, 11'h0C3, 11'h190};
		if (s == 2'h2)
			return {10'h0, 11'h320, 11'h5DC};
		return {10'h0, 11'h190, 11'h320};
	endfunction
	function automatic logic [31:0] exp_link();
		return {30'h0, analog_status.rate_in_range & use_local_clock & (analog_status.level_ok | !detector_enable),
			analog_status.rate_in_range & use_local_clock & analog_status.level_ok
			& analog_status.training_clock_present};
	endfunction
	function automatic logic sig(input int k);
		case (k)
			0: return s_axi_awready & s_axi_wready;
			1: return s_axi_bvalid;
			2: return s_axi_arready;
			default: return s_axi_rvalid;
		endcase
	endfunction
	task automatic hs(input int k);
		int n;
		n = 0;
		@(negedge aclk);
		while (sig(k) !== 1'b1)
		begin
			n++;
			if (n > 300)
			begin
				failures++;
				report_and_stop();
			end
			@(negedge aclk);
		end
		cap = s_axi_rdata;
		resp = (k == 1) ? s_axi_bresp : s_axi_rresp;
		@(posedge aclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		hs(0);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		hs(1);
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		hs(2);
		s_axi_arvalid <= 1'b0;
		hs(3);
	endtask
	task automatic rst(input logic [1:0] s);
		@(posedge aclk);
		aresetn <= 1'b0;
		rx_rate_range_sel <= s;
		tx_rate_range_sel <= ~s;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask
	initial
	begin
		for (int s = 0; s < 4; s++)
		begin
			rst(s[1:0]);
			@(negedge aclk);
			chk({10'h0, rx_rate_range}, rng(s[1:0]));
			chk({10'h0, tx_rate_range}, rng(~s[1:0]));
		end
		@(posedge aclk);
		rx_rate_range_sel <= 2'h2;
		rd(CTRL_OFFSET);
		chk(cap, 32'h4);
		chk({10'h0, rx_rate_range}, rng(2'h3));
		rd(INT_MASK_OFFSET);
		chk(cap, 32'h0);
		rd(4'h2);
		chk({30'h0, resp}, 32'h2);
		wr(4'h6, 32'h0);
		chk({30'h0, resp}, 32'h2);
		wr(STATUS_OFFSET, 32'hFFFFFFFF);
		chk({30'h0, resp}, 32'h0);
		for (int t = 0; t < 4; t++)
		begin
			wr(CTRL_OFFSET, 32'h4 | t);
			repeat (2) @(negedge aclk);
			chk({30'h0, level_trip_select}, t);
		end
		repeat (300)
		begin
			@(posedge aclk);
			seed = xs(seed);
			analog_status <= seed[2:0];
			detector_enable <= seed[3] | seed[4];
			use_local_clock <= seed[5] | seed[6];
			rx_input_select <= seed[7];
			@(posedge aclk);
			@(negedge aclk);
			chk({30'h0, receive_pll_tracks_data, link_fault_n}, exp_link());
		end
		@(posedge aclk);
		analog_status <= 3'h7;
		detector_enable <= 1'b1;
		use_local_clock <= 1'b1;
		stall <= 1'b1;
		repeat (50) @(posedge aclk);
		@(negedge aclk);
		chk({31'h0, link_fault_n}, 32'h1);
		repeat (20) @(posedge aclk);
		@(negedge aclk);
		chk({30'h0, receive_pll_tracks_data, link_fault_n}, 32'h0);
		rd(STATUS_OFFSET);
		chk(cap & 32'h4, 32'h4);
		detector_enable <= 1'b0;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk({30'h0, receive_pll_tracks_data, link_fault_n}, 32'h2);
		@(posedge aclk);
		stall <= 1'b0;
		detector_enable <= 1'b1;
		repeat (8) @(posedge aclk);
		@(negedge aclk);
		chk({30'h0, receive_pll_tracks_data, link_fault_n}, 32'h3);
		wr(CTRL_OFFSET, 32'h0);
		repeat (2) @(negedge aclk);
		chk({31'h0, link_fault_n}, 32'h0);
		wr(CTRL_OFFSET, 32'h4);
		rd(INT_STATUS_OFFSET);
		use_local_clock <= 1'b0;
		repeat (3) @(negedge aclk);
		chk({30'h0, irq, link_fault_n}, 32'h0);
		wr(INT_MASK_OFFSET, 32'h10);
		@(negedge aclk);
		chk({31'h0, irq}, 32'h1);
		rd(INT_STATUS_OFFSET);
		chk(cap & 32'h10, 32'h10);
		repeat (2) @(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
